// ==== bench/system_tick_timer_value_calib_tb.sv ====
// Self-checking bench for the tick timer
`timescale 1ns/1ns
`include "tick_timer_cfg.svh"
module system_tick_timer_value_calib_tb;
  import tick_timer_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  wb_req_t     wb_req = '0;
  logic        wb_nonsecure = 1'b0;
  wb_rsp_t     wb_rsp;
  logic        tick_clk_en = 1'b0;
  logic        dbg_halted = 1'b0;
  logic [1:0]  tick_exc_req;
  logic        irq;
  logic [31:0] rd;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc_cnt = 0;
  always #4 sys_clk = ~sys_clk;
  tick_timer DUT (.sys_clk(sys_clk), .rstn(rstn), .wb_req(wb_req), .wb_nonsecure(wb_nonsecure),
    .wb_rsp(wb_rsp), .tick_clk_en(tick_clk_en), .dbg_halted(dbg_halted), .tick_exc_req(tick_exc_req), .irq(irq));
  task automatic give_verdict();
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ns);
    @(posedge sys_clk);
    wb_req <= '{1'b1, 1'b1, w, a, `FULL_WORD_SEL, d};
    wb_nonsecure <= ns;
    do @(posedge sys_clk); while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic ns, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000, ns);
    chk(rd, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk) tick_clk_en <= 1'b1;
    @(posedge sys_clk) tick_clk_en <= 1'b0;
  endtask
  task automatic t_calib();
    rdc(`OFS_CALIBRATION, 1'b0, 32'hC000_0000);
    wb(1'b1, `OFS_CALIBRATION, 32'h3FFF_FFFF, 1'b0);
    rdc(`OFS_CALIBRATION, 1'b1, 32'hC000_0000);
    rdc(8'h3C, 1'b0, `WORD_ZERO);
  endtask
  task automatic t_count();
    wb(1'b1, `OFS_RELOAD, 32'hFF00_0003, 1'b0);
    wb(1'b1, `OFS_COUNT_VALUE, 32'h0000_0000, 1'b0);
    wb(1'b1, `OFS_CONTROL_STATUS, 32'h0000_0003, 1'b0);
    rdc(`OFS_RELOAD, 1'b0, 32'h0000_0003);
    tick(1);
    rdc(`OFS_COUNT_VALUE, 1'b0, 32'h0000_0003);
    tick(1);
    rdc(`OFS_COUNT_VALUE, 1'b0, 32'h0000_0002);
    @(posedge sys_clk) dbg_halted <= 1'b1;
    tick(3);
    dbg_halted <= 1'b0;
    rdc(`OFS_COUNT_VALUE, 1'b0, 32'h0000_0002);
  endtask
  task automatic t_event();
    wb(1'b1, `OFS_IRQ_MASK, 32'h0000_0000, 1'b0);
    tick(2);
    @(negedge sys_clk);
    chk({29'h0, tick_exc_req, irq}, 32'h0000_0002);
    rdc(`OFS_CONTROL_STATUS, 1'b0, 32'h0001_0007);
    rdc(`OFS_CONTROL_STATUS, 1'b0, 32'h0000_0007);
    rdc(`OFS_IRQ_STATUS, 1'b0, 32'h0000_0001);
    wb(1'b1, `OFS_IRQ_MASK, 32'h0000_0001, 1'b0);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0000_0001);
    wb(1'b1, `OFS_IRQ_STATUS, 32'h0000_0001, 1'b0);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask
  task automatic t_clear();
    tick(4);
    tick(3);
    // Count write lands on the tick that would step one to zero
    fork
      wb(1'b1, `OFS_COUNT_VALUE, 32'hABCD_1234, 1'b0);
      begin
        @(posedge sys_clk) tick_clk_en <= 1'b1;
        @(posedge sys_clk) tick_clk_en <= 1'b0;
        @(negedge sys_clk) chk({30'h0, tick_exc_req}, 32'h0000_0000);
      end
    join
    rdc(`OFS_COUNT_VALUE, 1'b0, 32'h0000_0000);
    rdc(`OFS_CONTROL_STATUS, 1'b0, 32'h0000_0007);
  endtask
  task automatic t_banks();
    rdc(`OFS_COUNT_VALUE, 1'b1, 32'h0000_0000);
    wb(1'b1, `OFS_RELOAD, 32'h0000_0005, 1'b1);
    rdc(`OFS_RELOAD, 1'b1, 32'h0000_0005);
    rdc(`OFS_RELOAD, 1'b0, 32'h0000_0003);
  endtask
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_calib();
    t_count();
    t_event();
    t_clear();
    t_banks();
    give_verdict();
  end
endmodule
bind tick_timer tick_timer_sva u_sva (.sys_clk(sys_clk), .rstn(rstn), .wb_req(wb_req), .wb_nonsecure(wb_nonsecure),
  .wb_rsp(wb_rsp), .tick_clk_en(tick_clk_en), .dbg_halted(dbg_halted), .tick_exc_req(tick_exc_req), .irq(irq));

// ==== bench/tick_timer_sva.sv ====
// Checker on the tick timer ports
`timescale 1ns/1ns
`include "tick_timer_cfg.svh"
module tick_timer_sva (
  // Clock and reset
  input wire logic                    sys_clk,
  input wire logic                    rstn,
  // Bus
  input wire tick_timer_pkg::wb_req_t wb_req,
  input wire logic                    wb_nonsecure,
  input wire tick_timer_pkg::wb_rsp_t wb_rsp,
  // Core side
  input wire logic                    tick_clk_en,
  input wire logic                    dbg_halted,
  input wire logic [1:0]              tick_exc_req,
  input wire logic                    irq
);
  import tick_timer_pkg::*;
  logic tk;
  logic rd;
  assign tk = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  assign rd = tk && !wb_req.we;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack too long");
  ack_answer_a: assert property (tk |=> wb_rsp.ack)
    else $error("no ack");
  dat_hold_a: assert property (!tk |=> $stable(wb_rsp.dat))
    else $error("read data moved");
  calib_value_a: assert property (rd && wb_req.adr == `OFS_CALIBRATION |=> wb_rsp.dat == 32'hC000_0000)
    else $error("bad calibration word");
  count_rsvd_a: assert property (rd && wb_req.adr == `OFS_COUNT_VALUE |=> wb_rsp.dat[31:24] == 8'h00)
    else $error("count upper bits set");
  write_quiet_a: assert property (tk && wb_req.we && wb_req.sel == `FULL_WORD_SEL && wb_req.adr == `OFS_COUNT_VALUE
    |=> tick_exc_req[$past(wb_nonsecure)] == 1'b0)
    else $error("count write raised request");
  gate_hold_a: assert property (tick_exc_req != 2'b00 |-> $past(tick_clk_en))
    else $error("request without tick");
  halt_hold_a: assert property (tick_exc_req != 2'b00 |-> !$past(dbg_halted))
    else $error("request while halted");
  exc_pulse_a: assert property (tick_exc_req != 2'b00 |=> tick_exc_req == 2'b00)
    else $error("request too long");
  cover property (tk && wb_req.we && wb_req.adr == `OFS_COUNT_VALUE);
  cover property (tick_exc_req[0]);
  cover property (irq);
endmodule

// ==== hw/tick_timer.sv ====
// Banked 24-bit down-counting system tick timer with Wishbone register access
// Summary of operation
// - Count register returns live count in bits 23:0, upper bits zero.
// - Full-word count write clears count and zero-reached flag.
// - One timer, nonsecure not owner: nonsecure count reads zero, writes ignored.
// - No timer built: count field reserved, reads zero.
// - Security plus two timers: separate banks chosen by accessing state.
// - Calibration bit 31 reads one: no reference clock.
// - Calibration bit 30 reads one: ten-millisecond value inexact.
// - Calibration count bits read zero; bits 29:24 reserved.
// - Counter advances only on controller clock enable; holds otherwise.
// - Enabled count decrements to zero, reloads next tick; zero reload stops.
// - Flag sets on one-to-zero step, clears on control read.
// - Count write never raises the timer exception request.
// - Count holds while processor is halted for debug.
`timescale 1ns/1ns
`include "tick_timer_cfg.svh"

module tick_timer #(
  parameter int unsigned NUM_TIMERS = 2,
  parameter bit          SECURE_EXT = 1'b1
) (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  // Wishbone slave
  input  wire tick_timer_pkg::wb_req_t wb_req,
  input  wire logic                    wb_nonsecure,
  output      tick_timer_pkg::wb_rsp_t wb_rsp,
  // Core status
  input  wire logic                    tick_clk_en,
  input  wire logic                    dbg_halted,
  // Requests
  output      logic [1:0]              tick_exc_req,
  output      logic                    irq
);
  import tick_timer_pkg::*;

  // ============================================================
  // Reset release
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ============================================================
  // Access decode
  state_t      s_q;
  state_t      s_d;
  logic        req;
  logic        wr;
  logic        rd;
  logic        ns_eff;
  logic        bsel;
  logic        timer_ok;
  logic [31:0] rd_word;
  bank_t       cur;

  always_comb begin
    req    = wb_req.cyc & wb_req.stb & ~s_q.ack;
    wr     = req & wb_req.we & (wb_req.sel == `FULL_WORD_SEL);
    rd     = req & ~wb_req.we;
    ns_eff = SECURE_EXT & wb_nonsecure;
    // Bank follows the accessing state only when both are built
    bsel   = (NUM_TIMERS == 2) && SECURE_EXT && ns_eff;
    timer_ok = (NUM_TIMERS != 0)
      && !(ns_eff && (NUM_TIMERS == 1) && !s_q.ns_owner);
    cur    = s_q.bank[bsel];
  end

  // ============================================================
  // Read data
  always_comb begin
    rd_word = `WORD_ZERO;
    case (wb_req.adr)
      `OFS_CONTROL_STATUS: begin
        if (timer_ok) begin
          rd_word[`CS_ENABLE_BIT]    = cur.enable;
          rd_word[`CS_TICKINT_BIT]   = cur.tickint;
          rd_word[`CS_CLKSRC_BIT]    = 1'b1;
          rd_word[`CS_ZERO_FLAG_BIT] = cur.zflag;
        end
      end
      `OFS_RELOAD: begin
        if (timer_ok) begin
          rd_word[`COUNT_W-1:0] = cur.reload;
        end
      end
      `OFS_COUNT_VALUE: begin
        if (timer_ok) begin
          rd_word[`COUNT_W-1:0] = cur.count;
        end
      end
      `OFS_CALIBRATION: begin
        if (timer_ok) begin
          rd_word[`CAL_NO_REFERENCE_CLOCK_BIT]   = 1'b1;
          rd_word[`CAL_INEXACT_BIT] = 1'b1;
          rd_word[`COUNT_W-1:0]     = `CAL_COUNT_VALUE;
        end
      end
      `OFS_IRQ_STATUS: begin
        rd_word[1:0] = s_q.irq_status;
      end
      `OFS_IRQ_MASK: begin
        rd_word[1:0] = s_q.irq_mask;
      end
      `OFS_SECURITY_CONFIG: begin
        rd_word[`CFG_NS_OWNER_BIT] = s_q.ns_owner;
      end
      default: begin
        rd_word = `WORD_ZERO;
      end
    endcase
  end

  // ============================================================
  // Next state
  always_comb begin
    logic tw;
    logic ctrl_wr;
    logic rel_wr;
    logic cnt_wr;
    logic ctrl_rd;
    tw      = 1'b0;
    ctrl_wr = 1'b0;
    rel_wr  = 1'b0;
    cnt_wr  = 1'b0;
    ctrl_rd = 1'b0;
    s_d     = s_q;
    s_d.ack = req;
    s_d.exc = 2'b00;
    if (req) begin
      s_d.rdata = rd_word;
    end
    // Status bits clear by writing one
    if (wr && (wb_req.adr == `OFS_IRQ_STATUS)) begin
      s_d.irq_status = s_q.irq_status & ~wb_req.dat[1:0];
    end
    if (wr && (wb_req.adr == `OFS_IRQ_MASK)) begin
      s_d.irq_mask = wb_req.dat[1:0];
    end
    // Ownership bit is writable from secure state only
    if (wr && !ns_eff && (wb_req.adr == `OFS_SECURITY_CONFIG)) begin
      s_d.ns_owner = wb_req.dat[`CFG_NS_OWNER_BIT];
    end
    for (int b = 0; b < `NUM_BANKS; b++) begin
      tw      = timer_ok && (b < NUM_TIMERS) && (bsel == b[0]);
      ctrl_wr = tw && wr && (wb_req.adr == `OFS_CONTROL_STATUS);
      rel_wr  = tw && wr && (wb_req.adr == `OFS_RELOAD);
      cnt_wr  = tw && wr && (wb_req.adr == `OFS_COUNT_VALUE);
      ctrl_rd = tw && rd && (wb_req.adr == `OFS_CONTROL_STATUS);
      if (ctrl_wr) begin
        s_d.bank[b].enable  = wb_req.dat[`CS_ENABLE_BIT];
        s_d.bank[b].tickint = wb_req.dat[`CS_TICKINT_BIT];
      end
      if (rel_wr) begin
        s_d.bank[b].reload = wb_req.dat[`COUNT_W-1:0];
      end
      if (ctrl_rd || cnt_wr) begin
        s_d.bank[b].zflag = 1'b0;
      end
      if (cnt_wr) begin
        s_d.bank[b].count = `COUNT_RESET;
      end else if (tick_clk_en && !dbg_halted && s_q.bank[b].enable && (b < NUM_TIMERS)) begin
        if (s_q.bank[b].count == `COUNT_RESET) begin
          s_d.bank[b].count = s_q.bank[b].reload;
        end else begin
          s_d.bank[b].count = s_q.bank[b].count - 24'h00_0001;
          if (s_q.bank[b].count == 24'h00_0001) begin
            // Set wins over a same-cycle clear
            s_d.bank[b].zflag    = 1'b1;
            s_d.irq_status[b]    = 1'b1;
            s_d.exc[b]           = s_q.bank[b].tickint;
          end
        end
      end
    end
    s_d.irq = |(s_d.irq_status & s_d.irq_mask);
  end

  // ============================================================
  // State register
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // Outputs
  assign wb_rsp       = '{ack: s_q.ack, dat: s_q.rdata};
  assign tick_exc_req = s_q.exc;
  assign irq          = s_q.irq;

endmodule

// ==== pkg/tick_timer_cfg.svh ====
// Register offsets, field positions, reset values and constants of the tick timer
`ifndef TICK_TIMER_CFG_SVH
`define TICK_TIMER_CFG_SVH

// ============================================================
// Register byte offsets
`define OFS_CONTROL_STATUS   8'h00
`define OFS_RELOAD           8'h04
`define OFS_COUNT_VALUE      8'h08
`define OFS_CALIBRATION      8'h0C
`define OFS_IRQ_STATUS       8'h10
`define OFS_IRQ_MASK         8'h14
`define OFS_SECURITY_CONFIG  8'h18

// ============================================================
// Field positions
`define CS_ENABLE_BIT        0
`define CS_TICKINT_BIT       1
`define CS_CLKSRC_BIT        2
`define CS_ZERO_FLAG_BIT     16
`define CAL_NO_REFERENCE_CLOCK_BIT        31
`define CAL_INEXACT_BIT      30
`define CFG_NS_OWNER_BIT     0

// ============================================================
// Widths and reset values
`define COUNT_W              24
`define NUM_BANKS            2
`define FULL_WORD_SEL        4'hF
`define COUNT_RESET          24'h00_0000
`define RELOAD_RESET         24'h00_0000
`define CAL_COUNT_VALUE      24'h00_0000
`define WORD_ZERO            32'h0000_0000

`endif

// ==== pkg/tick_timer_pkg.sv ====
// Types shared by the tick timer and its bench
package tick_timer_pkg;

  // ============================================================
  // Wishbone carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // ============================================================
  // One timer bank
  typedef struct packed {
    logic [23:0] count;
    logic [23:0] reload;
    logic        enable;
    logic        tickint;
    logic        zflag;
  } bank_t;

  // ============================================================
  // Whole block state
  typedef struct packed {
    bank_t [1:0] bank;
    logic        ns_owner;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic        irq;
    logic [1:0]  exc;
    logic        ack;
    logic [31:0] rdata;
  } state_t;

endpackage
